// *** src/raf_flow_ctrl.sv ***
// Per-ringlet add flow control: shapers, class B permit, hop limit
// Functional notes
// - class B permit is commit and downstream ok
// - stage queue accept input covers frame storage
// - check state: blocked queue gives hop zero
// - long reach: all ok gives max nodes
// - short reach: ok gives hops to choke
// - hop limit zero, hop count, or ring size
// - fair traffic bounded by static and dynamic rate
// - machine rows evaluated in priority order
// - credit below low limit drops pass
// - idle credit capped at low limit
// - low limit equals maximum frame bytes
// - waiting credit capped at high limit
// - credit grows by increment each interval
// - send needs low limit; credit never negative
// - all logic replicated per ringlet
// - class A split into subclass and control shapers
// - control shaper ok goes to control sublayer
// - class B commit or fair; class C fair
// - steered control frames use their path shapers
// - A1, B, C also need downstream shaper
`timescale 1ns/1ps
`include "raf_consts.svh"
module raf_flow_ctrl
(
  input  wire logic                     mclk_i,
  input  wire logic                     reset_i,
  input  wire logic [`RAF_TICK_W-1:0]   tick_interval_i,
  input  wire logic [`RAF_NSHAPER*`RAF_CREDIT_W-1:0] credit_increment_i,
  input  wire logic [`RAF_NSHAPER*`RAF_CREDIT_W-1:0] credit_high_limit_i,
  input  wire logic [`RAF_NSHAPER-1:0]  shaper_waiting_i,
  input  wire logic [`RAF_NSHAPER-1:0]  shaper_sent_i,
  input  wire logic [`RAF_FRAME_W-1:0]  credit_decrement_i,
  input  wire logic                     stage_accept_i,
  input  wire logic                     static_rate_ok_i,
  input  wire logic                     dynamic_rate_ok_i,
  input  wire logic [`RAF_HOP_W-1:0]    hops_to_choke_i,
  output logic                          classb_commit_permit_o,
  output logic [`RAF_HOP_W-1:0]         fair_hop_limit_o,
  output logic                          control_shaper_ok_o,
  output logic                          sub_a_zero_ok_o,
  output logic                          sub_a_one_ok_o,
  output logic [`RAF_NSHAPER-1:0]       shaper_ok_o
);
  import raf_pkg::*;

  // =====================================================
  // Update interval
  logic tick_w;  // One-cycle credit update enable

  // Configurable update interval from the MAC clock
  raf_tick_gen u_tick
  (
    .mclk_i     (mclk_i),
    .reset_i    (reset_i),
    .interval_i (tick_interval_i),
    .tick_o     (tick_w)
  );

  // =====================================================
  // Shaper bank, one bucket per shaper of this ringlet
  logic [`RAF_NSHAPER-1:0] pass_w;  // Pass flags of all shapers

  // Independent shapers: A0, A1, control, commit, fair, congested,
  // downstream; sender steering chooses which one is debited
  genvar gi;
  generate
    for (gi = 0; gi < `RAF_NSHAPER; gi++)
    begin : g_shaper
      raf_shaper u_shaper
      (
        .mclk_i              (mclk_i),
        .reset_i             (reset_i),
        .tick_i              (tick_w),
        .credit_increment_i  (credit_increment_i[gi*`RAF_CREDIT_W +:
                                                 `RAF_CREDIT_W]),
        .credit_high_limit_i (credit_high_limit_i[gi*`RAF_CREDIT_W +:
                                                  `RAF_CREDIT_W]),
        .waiting_i           (shaper_waiting_i[gi]),
        .sent_i              (shaper_sent_i[gi]),
        .credit_decrement_i  (credit_decrement_i),
        .pass_o              (pass_w[gi]),
        .credit_o            ()
      );
    end
  endgenerate

  // =====================================================
  // Named pass flags
  wire commit_shaper_ok_w;      // Committed rate shaper
  wire fair_shaper_ok_w;        // Fairness shaper
  wire congested_shaper_ok_w;   // Congested rate shaper
  wire downstream_shaper_ok_w;  // Downstream shaper

  assign commit_shaper_ok_w     = pass_w[`RAF_SH_COMMIT];
  assign fair_shaper_ok_w       = pass_w[`RAF_SH_FAIR];
  assign congested_shaper_ok_w  = pass_w[`RAF_SH_CONG];
  assign downstream_shaper_ok_w = pass_w[`RAF_SH_DOWN];
  assign shaper_ok_o            = pass_w;

  // Class A: control shaper straight to control sublayer
  assign control_shaper_ok_o = pass_w[`RAF_SH_CTRL];
  assign sub_a_zero_ok_o     = pass_w[`RAF_SH_A0];
  // Subclass A1 also needs the downstream shaper
  assign sub_a_one_ok_o      = pass_w[`RAF_SH_A1] & downstream_shaper_ok_w;

  // =====================================================
  // Class B committed permit
  logic permit_r;    // Registered permit
  wire  permit_nxt;  // Next permit

  // Accept input means storage or cut-through is ready
  // Commit and downstream both required
  assign permit_nxt = stage_accept_i ? (commit_shaper_ok_w &
                                        downstream_shaper_ok_w) : 1'b0;
  assign classb_commit_permit_o = permit_r;

  // Permit register
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      permit_r <= 1'b0;
    else
      permit_r <= permit_nxt;
  end

  // =====================================================
  // Fairness hop limit machine
  raf_fair_st_t         st_r;     // Current state
  raf_fair_st_t         st_nxt;   // Next state
  logic [`RAF_HOP_W-1:0] hop_r;   // Hop limit register
  logic [`RAF_HOP_W-1:0] hop_nxt; // Next hop limit
  wire                   long_ok_w;   // Past-choke conditions
  wire                   short_ok_w;  // Up-to-choke conditions

  // Long reach bounded by both rates; short by static rate
  assign long_ok_w  = dynamic_rate_ok_i & static_rate_ok_i &
                      congested_shaper_ok_w & downstream_shaper_ok_w;
  assign short_ok_w = static_rate_ok_i & fair_shaper_ok_w &
                      downstream_shaper_ok_w;
  assign fair_hop_limit_o = hop_r;

  // Rows checked first match wins
  always_comb
  begin
    st_nxt  = st_r;
    hop_nxt = hop_r;
    unique case (st_r)
      RAF_CHECK:
      begin
        if (stage_accept_i)
          st_nxt = RAF_LONG;
        else
          hop_nxt = `RAF_HOP_ZERO;
      end
      RAF_LONG:
      begin
        if (long_ok_w)
        begin
          hop_nxt = `RAF_MAX_RING_NODES;
          st_nxt  = RAF_CHECK;
        end
        else
          st_nxt = RAF_SHORT;
      end
      RAF_SHORT:
      begin
        hop_nxt = short_ok_w ? hops_to_choke_i : `RAF_HOP_ZERO;
        st_nxt  = RAF_CHECK;
      end
      default:
      begin
        hop_nxt = `RAF_HOP_ZERO;
        st_nxt  = RAF_CHECK;
      end
    endcase
  end

  // State and hop registers
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      st_r  <= RAF_CHECK;
      hop_r <= `RAF_HOP_ZERO;
    end
    else
    begin
      st_r  <= st_nxt;
      hop_r <= hop_nxt;
    end
  end

  // =====================================================
  // Checks
  property p_permit;
    @(posedge mclk_i) disable iff (reset_i)
    ##1 classb_commit_permit_o == $past(stage_accept_i &&
        commit_shaper_ok_w && downstream_shaper_ok_w);
  endproperty
  a_permit: assert property (p_permit)
    else $error("class B permit mismatch");

  property p_check_block;
    @(posedge mclk_i) disable iff (reset_i)
    (st_r == RAF_CHECK && !stage_accept_i)
      |=> (st_r == RAF_CHECK && fair_hop_limit_o == `RAF_HOP_ZERO);
  endproperty
  a_check_block: assert property (p_check_block)
    else $error("blocked check did not hold zero");

  property p_long_pass;
    @(posedge mclk_i) disable iff (reset_i)
    (st_r == RAF_LONG && long_ok_w)
      |=> (fair_hop_limit_o == `RAF_MAX_RING_NODES && st_r == RAF_CHECK);
  endproperty
  a_long_pass: assert property (p_long_pass)
    else $error("long reach did not give max nodes");

  property p_short;
    @(posedge mclk_i) disable iff (reset_i)
    (st_r == RAF_SHORT)
      |=> (st_r == RAF_CHECK && fair_hop_limit_o ==
           ($past(short_ok_w) ? $past(hops_to_choke_i) : `RAF_HOP_ZERO));
  endproperty
  a_short: assert property (p_short)
    else $error("short reach hop limit wrong");

  property p_sequence;
    @(posedge mclk_i) disable iff (reset_i)
    (st_r == RAF_CHECK && stage_accept_i) ##1 (!long_ok_w)
      |=> (st_r == RAF_SHORT) ##1 (st_r == RAF_CHECK);
  endproperty
  a_sequence: assert property (p_sequence)
    else $error("machine order wrong");

  property p_static_zero;
    @(posedge mclk_i) disable iff (reset_i)
    (st_r != RAF_CHECK && !static_rate_ok_i)
      |=> (fair_hop_limit_o == `RAF_HOP_ZERO || st_r == RAF_SHORT);
  endproperty
  a_static_zero: assert property (p_static_zero)
    else $error("hop limit nonzero over static rate");

  // Blocked queue clears the permit on the next cycle
  property p_permit_block;
    @(posedge mclk_i) disable iff (reset_i)
    !stage_accept_i |=> !classb_commit_permit_o;
  endproperty
  a_permit_block: assert property (p_permit_block)
    else $error("class B permit while queue blocked");

  // Ready queue moves to long reach and leaves the hop limit alone
  property p_check_go;
    @(posedge mclk_i) disable iff (reset_i)
    (st_r == RAF_CHECK && stage_accept_i)
      |=> (st_r == RAF_LONG && $stable(fair_hop_limit_o));
  endproperty
  a_check_go: assert property (p_check_go)
    else $error("check state did not move to long reach");

  // Failed long reach falls through to short reach, hop untouched
  property p_long_fail;
    @(posedge mclk_i) disable iff (reset_i)
    (st_r == RAF_LONG && !long_ok_w)
      |=> (st_r == RAF_SHORT && $stable(fair_hop_limit_o));
  endproperty
  a_long_fail: assert property (p_long_fail)
    else $error("long reach failure did not go to short");

  // Hop limit only ever takes one of its three meanings
  property p_hop_values;
    @(posedge mclk_i) disable iff (reset_i)
    !$stable(fair_hop_limit_o)
      |-> (fair_hop_limit_o == `RAF_HOP_ZERO ||
           fair_hop_limit_o == `RAF_MAX_RING_NODES ||
           fair_hop_limit_o == $past(hops_to_choke_i));
  endproperty
  a_hop_values: assert property (p_hop_values)
    else $error("hop limit took an illegal value");

  // Cycles since the last update tick, for the interval check
  logic [`RAF_TICK_W:0] tick_gap_r;  // One bit wider than the interval

  // Restart on every tick so the spacing can be measured
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      tick_gap_r <= '0;
    else if (tick_w)
      tick_gap_r <= {{`RAF_TICK_W{1'b0}}, 1'b1};
    else
      tick_gap_r <= tick_gap_r + 1'b1;
  end

  // Ticks come every interval plus one cycles
  property p_tick_gap;
    @(posedge mclk_i) disable iff (reset_i)
    tick_w |-> (tick_gap_r == ({1'b0, tick_interval_i} + 1'b1));
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("update interval spacing wrong");
endmodule

// *** pkg/raf_consts.svh ***
// Constants for the ring add flow control block
`ifndef RAF_CONSTS_SVH
`define RAF_CONSTS_SVH

// =====================================================
// Credit arithmetic
`define RAF_CREDIT_W        20
`define RAF_FRAME_W         14
`define RAF_MAX_FRAME_BYTES 20'h0_2400
// Low limit equals the maximum frame size
`define RAF_LOW_LIMIT       `RAF_MAX_FRAME_BYTES

// =====================================================
// Hop limit and ring size
`define RAF_HOP_W           8
`define RAF_MAX_RING_NODES  8'hff
`define RAF_HOP_ZERO        8'h00

// =====================================================
// Update interval
`define RAF_TICK_W          16
`define RAF_TICK_RST        16'h0000

// =====================================================
// Shaper index within one ringlet
`define RAF_NSHAPER         7
`define RAF_SH_A0           0
`define RAF_SH_A1           1
`define RAF_SH_CTRL         2
`define RAF_SH_COMMIT       3
`define RAF_SH_FAIR         4
`define RAF_SH_CONG         5
`define RAF_SH_DOWN         6

`endif

// *** pkg/raf_pkg.sv ***
// Types for the ring add flow control block
package raf_pkg;
  // Fairness permit machine states
  typedef enum logic [1:0]
  {
    RAF_CHECK = 2'b00,
    RAF_LONG  = 2'b01,
    RAF_SHORT = 2'b10
  } raf_fair_st_t;
endpackage

// *** src/raf_tick_gen.sv ***
// Update interval divider for the shaper token buckets
`timescale 1ns/1ps
`include "raf_consts.svh"
module raf_tick_gen
(
  input  wire logic                   mclk_i,
  input  wire logic                   reset_i,
  input  wire logic [`RAF_TICK_W-1:0] interval_i,
  output logic                        tick_o
);
  // =====================================================
  // Divider
  logic [`RAF_TICK_W-1:0] cnt_r;    // Cycles since last tick
  logic                   tick_r;   // Registered tick
  wire                    wrap_w;   // Interval reached

  assign wrap_w = (cnt_r >= interval_i);
  assign tick_o = tick_r;

  // Count cycles and emit a one-cycle enable at wrap
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      cnt_r  <= `RAF_TICK_RST;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= wrap_w ? `RAF_TICK_RST : cnt_r + 1'b1;
      tick_r <= wrap_w;
    end
  end
endmodule

// *** src/raf_shaper.sv ***
// One token-bucket rate shaper with low and high credit limits
`timescale 1ns/1ps
`include "raf_consts.svh"
module raf_shaper
(
  input  wire logic                     mclk_i,
  input  wire logic                     reset_i,
  input  wire logic                     tick_i,
  input  wire logic [`RAF_CREDIT_W-1:0] credit_increment_i,
  input  wire logic [`RAF_CREDIT_W-1:0] credit_high_limit_i,
  input  wire logic                     waiting_i,
  input  wire logic                     sent_i,
  input  wire logic [`RAF_FRAME_W-1:0]  credit_decrement_i,
  output logic                          pass_o,
  output logic [`RAF_CREDIT_W-1:0]      credit_o
);
  // =====================================================
  // Credit arithmetic
  logic [`RAF_CREDIT_W-1:0] credit_r;    // Bucket level
  logic [`RAF_CREDIT_W-1:0] credit_nxt;  // Next level
  logic [`RAF_CREDIT_W:0]   sum_w;       // Unsaturated sum
  logic [`RAF_CREDIT_W-1:0] cap_w;       // Applicable cap
  logic [`RAF_CREDIT_W-1:0] high_w;      // High limit, never below low
  logic [`RAF_CREDIT_W-1:0] inc_w;       // After increment
  logic [`RAF_CREDIT_W-1:0] dec_w;       // Decrement, widened

  // A high limit set under the frame size is raised to it
  assign high_w = (credit_high_limit_i < `RAF_LOW_LIMIT)
                ? `RAF_LOW_LIMIT : credit_high_limit_i;
  // Waiting frames may bank up to the high limit, idle only low
  assign cap_w = waiting_i ? high_w : `RAF_LOW_LIMIT;
  assign sum_w = {1'b0, credit_r} + {1'b0, credit_increment_i};
  assign inc_w = (sum_w > {1'b0, cap_w}) ? cap_w
               : sum_w[`RAF_CREDIT_W-1:0];
  assign dec_w = {{(`RAF_CREDIT_W-`RAF_FRAME_W){1'b0}}, credit_decrement_i};

  // Pass flag drops once credit falls below the low limit
  assign pass_o   = (credit_r >= `RAF_LOW_LIMIT);
  assign credit_o = credit_r;

  // Next credit: subtract on send, never below zero
  // Otherwise add the increment on tick, saturating at the cap
  always_comb
  begin
    credit_nxt = credit_r;
    if (sent_i)
      credit_nxt = (credit_r > dec_w) ? credit_r - dec_w : '0;
    else if (tick_i)
      credit_nxt = (credit_r > cap_w) ? credit_r : inc_w;
  end

  // Bucket register starts full at the low limit
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      credit_r <= `RAF_LOW_LIMIT;
    else
      credit_r <= credit_nxt;
  end

  // =====================================================
  // Checks
  property p_credit_cap;
    @(posedge mclk_i) disable iff (reset_i)
    (tick_i && !sent_i && credit_r <= cap_w) |=> (credit_r <= $past(cap_w));
  endproperty
  a_credit_cap: assert property (p_credit_cap)
    else $error("credit exceeded cap");

  property p_no_wrap;
    @(posedge mclk_i) disable iff (reset_i)
    sent_i |=> (credit_r <= $past(credit_r));
  endproperty
  a_no_wrap: assert property (p_no_wrap)
    else $error("credit grew on send");

  property p_pass_low;
    @(posedge mclk_i) disable iff (reset_i)
    (sent_i && (credit_r < `RAF_LOW_LIMIT + dec_w)) |=> !pass_o;
  endproperty
  a_pass_low: assert property (p_pass_low)
    else $error("pass while below low limit");

  property p_increment;
    @(posedge mclk_i) disable iff (reset_i)
    (tick_i && !sent_i && sum_w <= {1'b0, cap_w})
      |=> (credit_r == $past(credit_r) + $past(credit_increment_i));
  endproperty
  a_increment: assert property (p_increment)
    else $error("credit not incremented");
endmodule

// *** verif/raf_client_model.sv ***
// Client side model that turns bench requests into shaper send pulses
`timescale 1ns/1ps
module raf_client_model
(
  input  wire logic [7:0] hop_limit_i,
  input  wire logic       fair_req_i,
  input  wire logic [7:0] dest_hops_i,
  input  wire logic [6:0] raw_sent_i,
  output logic      [6:0] shaper_sent_o
);
  // =====================================================
  // Fair frame release
  logic fair_go;  // Fair frame actually leaves the client

  // Leaves only within the hop limit, and never while the limit is zero
  assign fair_go = fair_req_i && (hop_limit_i != 8'h00)
                   && (dest_hops_i <= hop_limit_i);

  // =====================================================
  // Send pulses
  // Bench pulses plus the debit of the fair shaper, index 4
  assign shaper_sent_o = raw_sent_i | {2'b00, fair_go, 4'h0};
endmodule

// *** verif/tb_top.sv ***
// Self-checking testbench for the ring add flow control block
`timescale 1ns/1ps
`include "raf_consts.svh"
module tb_top;
  import raf_pkg::*;
  // =====================================================
  // Stimulus, outputs and counters
  logic        mclk_i   = 1'b0;   // 40 MHz clock
  logic        reset_i  = 1'b1;   // Held for the first cycles
  logic [13:0] dec      = 14'h3fff;
  logic        accept   = 1'b0;   // Stage queue can accept
  logic        st_ok    = 1'b1;
  logic        dy_ok    = 1'b1;
  logic [6:0]  raw_sent = 7'h00;  // Direct send pulses
  logic [6:0]  raw_wait = 7'h00;  // Frames waiting per shaper
  logic        fair_req = 1'b0;   // Client offers a fair frame
  logic        permit;
  logic [7:0]  hop;
  logic        ctrl_ok;
  logic        a0_ok;
  logic        a1_ok;
  logic [6:0]  ok;
  logic [6:0]  sent;
  int          errors   = 0;
  int          checks   = 0;

  // Clock
  always #12.5 mclk_i = ~mclk_i;

  // =====================================================
  // Design and client model
  raf_flow_ctrl dut
  (
    .mclk_i                 (mclk_i),
    .reset_i                (reset_i),
    .tick_interval_i        (16'h0003),
    .credit_increment_i     ({7{20'h0_0100}}),
    .credit_high_limit_i    ({7{20'h0_4800}}),
    .shaper_waiting_i       (raw_wait),
    .shaper_sent_i          (sent),
    .credit_decrement_i     (dec),
    .stage_accept_i         (accept),
    .static_rate_ok_i       (st_ok),
    .dynamic_rate_ok_i      (dy_ok),
    .hops_to_choke_i        (8'h05),
    .classb_commit_permit_o (permit),
    .fair_hop_limit_o       (hop),
    .control_shaper_ok_o    (ctrl_ok),
    .sub_a_zero_ok_o        (a0_ok),
    .sub_a_one_ok_o         (a1_ok),
    .shaper_ok_o            (ok)
  );

  raf_client_model client
  (
    .hop_limit_i   (hop),
    .fair_req_i    (fair_req),
    .dest_hops_i   (8'h05),
    .raw_sent_i    (raw_sent),
    .shaper_sent_o (sent)
  );

  // =====================================================
  // Tasks
  // Wait a number of falling edges
  task cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One-cycle send pulse on shaper s, then let the debit land
  task drain(input int s);
    raw_sent <= 7'h01 << s;
    cyc(1);
    raw_sent <= 7'h00;
    cyc(1);
  endtask

  // Verdict and end of run
  task final_report;
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // =====================================================
  // Main sequence
  initial
  begin
    cyc(10);
    reset_i <= 1'b0;
    chk(permit, 1'b0);
    chk(ok, 7'h7f);
    cyc(4);
    chk(hop, `RAF_HOP_ZERO);
    accept <= 1'b1;
    cyc(4);
    chk(permit, 1'b1);
    chk(hop, `RAF_MAX_RING_NODES);
    // Fairness flag table, every combination
    for (int i = 0; i < 4; i++)
    begin
      st_ok <= ~i[1];
      dy_ok <= ~i[0];
      cyc(6);
      chk(hop, (i == 0) ? `RAF_MAX_RING_NODES
               : (i == 1) ? 8'h05 : `RAF_HOP_ZERO);
    end
    st_ok <= 1'b1;
    dy_ok <= 1'b1;
    // Empty each shaper in turn and watch every indication
    for (int k = 0; k < 7; k++)
    begin
      drain(k);
      cyc(1);
      chk(ok, 7'h7f & ~(7'h01 << k));
      chk(a1_ok, k != 1 && k != 6);
      chk(ctrl_ok, k != 2);
      chk(a0_ok, k != 0);
      cyc(4);
      chk(permit, k != 3 && k != 6);
      chk(hop, (k == 6) ? `RAF_HOP_ZERO
               : (k == 5) ? 8'h05 : `RAF_MAX_RING_NODES);
      cyc(160);
    end
    // Oversized debit clamps at zero, then refill takes 36 ticks
    drain(3);
    cyc(129);
    chk(ok[3], 1'b0);
    cyc(26);
    chk(ok[3], 1'b1);
    // Idle credit stops at the low limit, even after a long idle spell
    cyc(160);
    dec <= 14'h2400;
    drain(3);
    cyc(1);
    chk(ok[3], 1'b0);
    cyc(160);
    // Waiting credit climbs to the high limit
    raw_wait <= 7'h08;
    cyc(200);
    drain(3);
    cyc(1);
    chk(ok[3], 1'b1);
    raw_wait <= 7'h00;
    cyc(160);
    // Client holds fair frames while the limit is zero
    st_ok <= 1'b0;
    cyc(6);
    fair_req <= 1'b1;
    cyc(1);
    fair_req <= 1'b0;
    cyc(2);
    chk(ok[4], 1'b1);
    st_ok <= 1'b1;
    cyc(6);
    fair_req <= 1'b1;
    cyc(1);
    fair_req <= 1'b0;
    cyc(2);
    chk(ok[4], 1'b0);
    // Queue blocked again
    accept <= 1'b0;
    cyc(4);
    chk(permit, 1'b0);
    chk(hop, `RAF_HOP_ZERO);
    final_report;
  end

  // Watchdog: the sequence needs about 2080 cycles
  initial
  begin
    repeat (5000) @(posedge mclk_i);
    errors++;
    final_report;
  end
endmodule
